// >>> rtl/dgc_decimator_gain_control.sv
// Decimator output digital gain stage with its control and read-back registers
// Summary of operation
// - Control register write-only; read-back returns it
// - Override clear: automatic gain, coefficients ignored
// - Gain equals (32 + 4*coarse + fine)/26
// - Coarse codes map to -2..+2
// - Coarse unused codes clamp to +2 or -2
// - Fine field decodes like coarse field
`timescale 1ns/10ps
`default_nettype none
module dgc_decimator_gain_control
    import dgc_pkg::*;
(
    input  wire logic                           clk_sys,
    input  wire logic                           rst,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    input  wire logic [DGC_ADDR_W-1:0]          reg_addr,
    input  wire logic [DGC_DATA_W-1:0]          reg_wr_data,
    output logic      [DGC_DATA_W-1:0]          reg_rd_data,
    input  wire logic                           overload_recovery_mode,
    input  wire logic                           in_valid,
    input  wire logic signed [DGC_SAMPLE_W-1:0] in_data,
    output logic                                out_valid,
    output logic signed [DGC_SAMPLE_W-1:0]      out_data
);

    logic [DGC_DATA_W-1:0]        ctrl;
    logic                         custom_gain_override;
    logic [2:0]                   coarse_code;
    logic [2:0]                   fine_code;
    logic signed [2:0]            coarse_gain_coeff;
    logic signed [2:0]            fine_gain_coeff;
    logic signed [DGC_GAIN_W-1:0] gain_num;
    logic signed [DGC_PROD_W-1:0] product;
    logic signed [DGC_PROD_W-1:0] scaled;
    logic signed [DGC_SAMPLE_W-1:0] next_out;

    // Unused codes saturate toward the nearest legal extreme
    function automatic logic signed [2:0] dgc_decode(input logic [2:0] code);
        logic signed [2:0] val;
        val = 3'sh0;
        case (code)
            3'h3, 3'h2: val = 3'sh2;
            3'h1:       val = 3'sh1;
            3'h0:       val = 3'sh0;
            3'h7:       val = -3'sh1;
            default:    val = -3'sh2;
        endcase
        return val;
    endfunction

    // Independent decode used only by the assertions below
    function automatic logic signed [7:0] dgc_ref_coeff(input logic [2:0] code);
        logic signed [7:0] val;
        val = 8'sh00;
        if (!code[2]) begin
            val = code[1] ? 8'sh02 : {7'h00, code[0]};
        end else begin
            val = (code[1:0] == 2'h3) ? -8'sh01 : -8'sh02;
        end
        return val;
    endfunction

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl <= DGC_CTRL_RESET;
        end else if (reg_wr && reg_addr == DGC_ADDR_CTRL) begin
            ctrl <= reg_wr_data;
        end
    end

    // Write-only address reads zero; read-back address shows the control word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == DGC_ADDR_READBACK) begin
                reg_rd_data <= ctrl;
            end else begin
                reg_rd_data <= 8'h00;
            end
        end
    end

    assign custom_gain_override = ctrl[DGC_OVERRIDE_BIT];

    always_comb begin
        if (custom_gain_override) begin
            coarse_code = ctrl[DGC_COARSE_MSB:DGC_COARSE_LSB];
            fine_code   = ctrl[DGC_FINE_MSB:DGC_FINE_LSB];
        end else if (overload_recovery_mode) begin
            coarse_code = DGC_AUTO_RECOV_COARSE;
            fine_code   = DGC_AUTO_RECOV_FINE;
        end else begin
            coarse_code = DGC_AUTO_CLIP_COARSE;
            fine_code   = DGC_AUTO_CLIP_FINE;
        end
    end

    assign coarse_gain_coeff = dgc_decode(coarse_code);
    assign fine_gain_coeff   = dgc_decode(fine_code);

    // Numerator stays within 22..42, divisor applied after the multiply
    assign gain_num = DGC_GAIN_BASE
                    + (DGC_GAIN_W'(coarse_gain_coeff) <<< DGC_COARSE_SHIFT)
                    + DGC_GAIN_W'(fine_gain_coeff);
    assign product  = DGC_PROD_W'(in_data) * DGC_PROD_W'(gain_num);
    assign scaled   = product / DGC_PROD_W'(DGC_GAIN_DIVISOR);

    always_comb begin
        if (scaled > DGC_PROD_W'(DGC_SAMPLE_MAX)) begin
            next_out = DGC_SAMPLE_MAX;
        end else if (scaled < DGC_PROD_W'(DGC_SAMPLE_MIN)) begin
            next_out = DGC_SAMPLE_MIN;
        end else begin
            next_out = scaled[DGC_SAMPLE_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= 16'sh0000;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_data <= next_out;
            end
        end
    end

    ctrl_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == DGC_ADDR_CTRL) ##1 (reg_rd && !reg_wr && reg_addr == DGC_ADDR_READBACK)
        |=> reg_rd_data == $past(reg_wr_data, 2))
        else $error("read-back does not match last control write");

    wo_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == DGC_ADDR_CTRL) |=> reg_rd_data == 8'h00)
        else $error("write-only control register read non-zero");

    unmapped_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr != DGC_ADDR_CTRL && reg_addr != DGC_ADDR_READBACK) |=> reg_rd_data == 8'h00)
        else $error("unmapped address read non-zero");

    ro_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr != DGC_ADDR_CTRL) |=> $stable(ctrl))
        else $error("write to other address changed control word");

    rd_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        !reg_rd |=> $stable(reg_rd_data))
        else $error("read data changed without a read");

    auto_clip_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!custom_gain_override && !overload_recovery_mode) |-> gain_num == DGC_NUM_CLIP)
        else $error("clipping mode gain is not unity");

    auto_recov_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!custom_gain_override && overload_recovery_mode) |-> gain_num == DGC_NUM_RECOV)
        else $error("recovery mode ignores automatic gain");

    auto_coeff_a: assert property (@(posedge clk_sys) disable iff (rst)
        !custom_gain_override |->
        coarse_gain_coeff == (overload_recovery_mode ? 3'sh1 : -3'sh1))
        else $error("automatic gain follows coefficient field");

    custom_gain_a: assert property (@(posedge clk_sys) disable iff (rst)
        custom_gain_override |->
        gain_num == DGC_GAIN_BASE
                    + (dgc_ref_coeff(ctrl[DGC_COARSE_MSB:DGC_COARSE_LSB]) <<< DGC_COARSE_SHIFT)
                    + dgc_ref_coeff(ctrl[DGC_FINE_MSB:DGC_FINE_LSB]))
        else $error("custom gain numerator wrong");

    coarse_map_a: assert property (@(posedge clk_sys) disable iff (rst)
        custom_gain_override |->
        DGC_GAIN_W'(coarse_gain_coeff) == dgc_ref_coeff(ctrl[DGC_COARSE_MSB:DGC_COARSE_LSB]))
        else $error("coarse code mapping wrong");

    coarse_clamp_a: assert property (@(posedge clk_sys) disable iff (rst)
        ((custom_gain_override && ctrl[5:3] == 3'h3) |-> coarse_gain_coeff == 3'sh2)
        and ((custom_gain_override && ctrl[5:4] == 2'h2) |-> coarse_gain_coeff == -3'sh2))
        else $error("unused coarse code not clamped");

    fine_map_a: assert property (@(posedge clk_sys) disable iff (rst)
        ((custom_gain_override && ctrl[2:0] == 3'h7) |-> fine_gain_coeff == -3'sh1)
        and ((custom_gain_override && ctrl[2:1] == 2'h2) |-> fine_gain_coeff == -3'sh2))
        else $error("fine code mapping wrong");

    fine_ref_a: assert property (@(posedge clk_sys) disable iff (rst)
        custom_gain_override |->
        DGC_GAIN_W'(fine_gain_coeff) == dgc_ref_coeff(ctrl[DGC_FINE_MSB:DGC_FINE_LSB]))
        else $error("fine code decode differs from coarse mapping");

    gain_path_a: assert property (@(posedge clk_sys) disable iff (rst)
        (in_valid && !custom_gain_override && !overload_recovery_mode)
        |=> out_valid && out_data == $past(in_data))
        else $error("unity gain path alters sample");

    recov_out_a: assert property (@(posedge clk_sys) disable iff (rst)
        (in_valid && !custom_gain_override && overload_recovery_mode && in_data == 16'shffe5)
        |=> out_data == 16'shffdc)
        else $error("recovery mode sample not scaled by 35/26");

    sat_high_a: assert property (@(posedge clk_sys) disable iff (rst)
        (in_valid && in_data == DGC_SAMPLE_MAX && gain_num > DGC_GAIN_DIVISOR) |=> out_data == DGC_SAMPLE_MAX)
        else $error("high sample not saturated");

    sat_low_a: assert property (@(posedge clk_sys) disable iff (rst)
        (in_valid && in_data == DGC_SAMPLE_MIN && gain_num > DGC_GAIN_DIVISOR) |=> out_data == DGC_SAMPLE_MIN)
        else $error("low sample not saturated");

    out_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        !in_valid |=> !out_valid && $stable(out_data))
        else $error("output changed without an input sample");

    gain_range_a: assert property (@(posedge clk_sys) disable iff (rst)
        gain_num >= DGC_GAIN_BASE - 8'sh0a && gain_num <= DGC_GAIN_BASE + 8'sh0a)
        else $error("gain numerator out of range");
endmodule
`default_nettype wire

// >>> include/dgc_pkg.sv
// Constants for the decimator digital gain control block
`default_nettype none
package dgc_pkg;
    localparam int          DGC_ADDR_W        = 8;
    localparam int          DGC_DATA_W        = 8;
    localparam int          DGC_SAMPLE_W      = 16;
    localparam int          DGC_GAIN_W        = 8;
    localparam int          DGC_PROD_W        = DGC_SAMPLE_W + DGC_GAIN_W;

    // Register map
    localparam logic [7:0]  DGC_ADDR_CTRL     = 8'h14;
    localparam logic [7:0]  DGC_ADDR_READBACK = 8'h15;
    localparam logic [7:0]  DGC_CTRL_RESET    = 8'h00;

    // Field positions in the control register
    localparam int          DGC_OVERRIDE_BIT  = 7;
    localparam int          DGC_COARSE_MSB    = 5;
    localparam int          DGC_COARSE_LSB    = 3;
    localparam int          DGC_FINE_MSB      = 2;
    localparam int          DGC_FINE_LSB      = 0;

    // Gain factor = (base + 4*coarse + fine) / divisor
    localparam logic signed [7:0] DGC_GAIN_BASE    = 8'sh20;
    localparam logic signed [7:0] DGC_GAIN_DIVISOR = 8'sh1a;
    localparam int                DGC_COARSE_SHIFT = 2;

    // Automatic coefficient settings per operating mode
    localparam logic [2:0]  DGC_AUTO_RECOV_COARSE = 3'h1;
    localparam logic [2:0]  DGC_AUTO_RECOV_FINE   = 3'h7;
    localparam logic [2:0]  DGC_AUTO_CLIP_COARSE = 3'h7;
    localparam logic [2:0]  DGC_AUTO_CLIP_FINE   = 3'h6;

    // Numerators the automatic settings resolve to
    localparam logic signed [7:0] DGC_NUM_RECOV = 8'sh23;
    localparam logic signed [7:0] DGC_NUM_CLIP = 8'sh1a;

    localparam logic signed [15:0] DGC_SAMPLE_MAX = 16'sh7fff;
    localparam logic signed [15:0] DGC_SAMPLE_MIN = -16'sh8000;
endpackage
`default_nettype wire

// >>> bench/dgc_decimator_gain_control_tb.sv
// Self-checking bench for the decimator gain control block
`timescale 1ns/10ps
`default_nettype none
module dgc_decimator_gain_control_tb
    import dgc_pkg::*;
;
    logic               clk_sys = 1'b0;
    logic               rst = 1'b1;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [7:0]         reg_addr = 8'h00;
    logic [7:0]         reg_wr_data = 8'h00;
    logic [7:0]         reg_rd_data;
    logic               overload_recovery_mode = 1'b0;
    logic               in_valid = 1'b0;
    logic signed [15:0] in_data = 16'sh0000;
    logic               out_valid;
    logic signed [15:0] out_data;
    int                 mismatches = 0;
    int                 comparisons = 0;

    dgc_decimator_gain_control dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .overload_recovery_mode(overload_recovery_mode), .in_valid(in_valid), .in_data(in_data),
        .out_valid(out_valid), .out_data(out_data));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1; reg_addr <= a; reg_wr_data <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rd_data;
    endtask

    // Control write followed at once by a read-back
    task automatic wr_rd(input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= DGC_ADDR_CTRL;
        reg_wr_data <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= DGC_ADDR_READBACK;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 q = reg_rd_data;
    endtask

    // One sample in, gained sample out one cycle later
    task automatic smp(input logic signed [15:0] x, output logic signed [15:0] y);
        @(posedge clk_sys);
        in_valid <= 1'b1; in_data <= x;
        @(posedge clk_sys);
        in_valid <= 1'b0;
        #1 y = out_data;
        check("out_valid", {15'h0000, out_valid}, 16'h0001);
    endtask

    function automatic int dec(input logic [2:0] c);
        case (c)
            3'h3, 3'h2: return 2;
            3'h1: return 1;
            3'h0: return 0;
            3'h7: return -1;
            default: return -2;
        endcase
    endfunction

    // Truncates toward zero, then saturates to the sample range
    function automatic logic [15:0] gained(input int x, input int n);
        int p;
        p = (x * n) / 26;
        if (p > 32767) p = 32767;
        if (p < -32768) p = -32768;
        return 16'(p);
    endfunction

    initial begin
        #200000;
        mismatches++;
        close_out;
    end

    initial begin
        logic [7:0]         d;
        logic signed [15:0] y;
        int                 n;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd(DGC_ADDR_READBACK, d);
        check("readback after reset", {8'h00, d}, {8'h00, DGC_CTRL_RESET});
        wr(DGC_ADDR_CTRL, 8'h5a);
        rd(DGC_ADDR_READBACK, d);
        check("readback", {8'h00, d}, 16'h005a);
        rd(8'h16, d);
        check("unmapped read", {8'h00, d}, 16'h0000);
        rd(DGC_ADDR_READBACK, d);
        check("readback again", {8'h00, d}, 16'h005a);
        rd(DGC_ADDR_CTRL, d);
        check("control read", {8'h00, d}, 16'h0000);
        wr(DGC_ADDR_READBACK, 8'h33);
        rd(DGC_ADDR_READBACK, d);
        check("readback after write to it", {8'h00, d}, 16'h005a);
        wr_rd(8'hc5, d);
        check("back-to-back readback", {8'h00, d}, 16'h00c5);
        // Override clear: coefficients set but must be ignored
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_sys);
            overload_recovery_mode <= m[0];
            wr(DGC_ADDR_CTRL, 8'h7f);
            smp(-16'sd27, y);
            check("auto gain", y, gained(-27, (m == 1) ? 35 : 26));
        end
        for (int c = 0; c < 64; c++) begin
            wr(DGC_ADDR_CTRL, {2'b10, c[5:0]});
            n = 32 + 4 * dec(c[5:3]) + dec(c[2:0]);
            smp(16'sd1001, y);
            check("custom gain", y, gained(1001, n));
        end
        wr(DGC_ADDR_CTRL, 8'h92);
        smp(DGC_SAMPLE_MAX, y);
        check("saturate high", y, 16'h7fff);
        @(posedge clk_sys);
        #1;
        check("out_data hold", out_data, 16'h7fff);
        check("out_valid drop", {15'h0000, out_valid}, 16'h0000);
        smp(DGC_SAMPLE_MIN, y);
        check("saturate low", y, 16'h8000);
        close_out;
    end
endmodule
`default_nettype wire
